// ---- rtl/scsi_host_config_space.sv ----
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - both-buffer requests allowed when feature 0
// - report hot-plug events when feature 1
// - report parameter-change events when feature 2
// - protection feature 3 can be negotiated; request protection fields are not used
// - report number of request queues
// - report segment limit per command
// - transfer size is an advisory hint only
// - event fill size follows negotiated features
// - sense size defaults to 96, writable
// - command block size defaults to 32, writable
// - reset restores sense and command sizes
// - channel 0, target 255, unit 16383
// - accept requests once initialization completes
// - both buffers without feature fail at once
module scsi_host_config_space
   import scsi_cfg_pkg::*;
   (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire reg_req_t i_reg,
   output logic [31:0] o_rdata,
   input wire logic [3:0] i_drv_features,
   input wire logic i_features_valid,
   input wire logic i_unit_hotplug,
   input wire logic i_unit_param_change,
   input wire cmd_req_t i_cmd,
   output cmd_rsp_t o_cmd_rsp,
   output logic o_cmd_accept,
   output logic [3:0] o_features,
   output logic [31:0] o_sense_size,
   output logic [31:0] o_cdb_size,
   output logic o_hotplug_event,
   output logic o_param_event,
   output logic o_irq
   );

   logic [31:0] sense_size_q;
   logic [31:0] cdb_size_q;
   logic [3:0] feat_q;
   logic [1:0] ctrl_q;
   logic [IRQ_W-1:0] irq_status_q;
   logic [IRQ_W-1:0] irq_enable_q;
   logic [IRQ_W-1:0] irq_set;
   logic [31:0] fail_count_q;
   logic [31:0] rdata_raw;
   logic [31:0] rdata_ord;
   logic [31:0] wdata_ord;
   logic [31:0] event_fill;
   logic cmd_fail;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // legacy mode swaps byte order on all reads and on sense/command size writes
   byte_order_swap u_swap_wr
   (
      .i_swap (ctrl_q[CTRL_LEGACY]),
      .i_data (i_reg.wdata),
      .o_data (wdata_ord)
   );

   // negotiated features: offered set masked by driver choice
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         feat_q <= 4'h0;
      else if (i_features_valid)
         feat_q <= i_drv_features & FEAT_OFFERED;
   end

   // of the config fields only the two sizes accept writes; the read-only ones ignore them
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         sense_size_q <= SENSE_SIZE_RST;
         cdb_size_q <= CDB_SIZE_RST;
      end
      else if (i_reg.wr)
      begin
         if (hit(i_reg.addr, OFF_SENSE_SIZE))
            sense_size_q <= wdata_ord;
         if (hit(i_reg.addr, OFF_CDB_SIZE))
            cdb_size_q <= wdata_ord;
      end
   end

   // control writes are not byte-swapped so legacy can always be cleared
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         ctrl_q <= 2'b00;
      else if (i_reg.wr && hit(i_reg.addr, OFF_CTRL))
         ctrl_q <= i_reg.wdata[1:0];
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         irq_enable_q <= '0;
      else if (i_reg.wr && hit(i_reg.addr, OFF_IRQ_ENABLE))
         irq_enable_q <= i_reg.wdata[IRQ_W-1:0];
   end

   // event fill grows when hot-plug or change reporting is negotiated
   always_comb
   begin
      event_fill = EVENT_FILL_BASE;
      if (feat_q[FEAT_CHANGE] || feat_q[FEAT_HOTPLUG])
         event_fill = 32'(EVENT_FILL_BASE + EVENT_FILL_EXT);
   end

   // both buffers without the in/out feature fail immediately
   always_comb
   begin
      cmd_fail = i_cmd.has_out && i_cmd.has_in
         && !feat_q[FEAT_INOUT];
   end

   always_comb
   begin
      irq_set = '0;
      irq_set[IRQ_HOTPLUG] = i_unit_hotplug && feat_q[FEAT_HOTPLUG];
      irq_set[IRQ_PARAM] = i_unit_param_change
         && feat_q[FEAT_CHANGE];
      irq_set[IRQ_REQ_FAIL] = i_cmd.valid && ctrl_q[CTRL_READY] && cmd_fail;
   end

   // set wins over a same-cycle clear
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         irq_status_q <= '0;
      else if (i_reg.wr && hit(i_reg.addr, OFF_IRQ_CLEAR))
         irq_status_q <= (irq_status_q & ~i_reg.wdata[IRQ_W-1:0]) | irq_set;
      else
         irq_status_q <= irq_status_q | irq_set;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_irq <= 1'b0;
      else
         o_irq <= |((irq_status_q | irq_set) & irq_enable_q);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_hotplug_event <= 1'b0;
         o_param_event <= 1'b0;
      end
      else
      begin
         o_hotplug_event <= irq_set[IRQ_HOTPLUG];
         o_param_event <= irq_set[IRQ_PARAM];
      end
   end

   // requests answered next cycle once ready is set
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_cmd_rsp <= '0;
         fail_count_q <= '0;
      end
      else
      begin
         o_cmd_rsp.valid <= i_cmd.valid && ctrl_q[CTRL_READY];
         o_cmd_rsp.resp <= cmd_fail ? RESP_FAILURE : RESP_OK;
         if (i_cmd.valid && ctrl_q[CTRL_READY] && cmd_fail)
            fail_count_q <= 32'(fail_count_q + 32'h0000_0001);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_cmd_accept <= 1'b0;
         o_features <= 4'h0;
         o_sense_size <= SENSE_SIZE_RST;
         o_cdb_size <= CDB_SIZE_RST;
      end
      else
      begin
         o_cmd_accept <= ctrl_q[CTRL_READY];
         o_features <= feat_q;
         o_sense_size <= sense_size_q;
         o_cdb_size <= cdb_size_q;
      end
   end

   always_comb
   begin
      rdata_raw = 32'h0000_0000;
      case (i_reg.addr)
         OFF_QUEUE_COUNT: rdata_raw = QUEUE_COUNT_VAL;
         OFF_SEG_MAX: rdata_raw = SEG_MAX_VAL;
         OFF_XFER_HINT: rdata_raw = XFER_HINT_VAL;
         OFF_LINKED_LIMIT: rdata_raw = LINKED_LIMIT_VAL;
         OFF_EVENT_FILL: rdata_raw = event_fill;
         OFF_SENSE_SIZE: rdata_raw = sense_size_q;
         OFF_CDB_SIZE: rdata_raw = cdb_size_q;
         OFF_CHAN_TGT: rdata_raw = {TGT_LIMIT_VAL, CHAN_LIMIT_VAL};
         OFF_UNIT_LIMIT: rdata_raw = UNIT_LIMIT_VAL;
         OFF_FEATURES: rdata_raw = {28'h000_0000, feat_q};
         OFF_CTRL: rdata_raw = {30'h0000_0000, ctrl_q};
         OFF_IRQ_STATUS: rdata_raw = {29'h0000_0000, irq_status_q};
         OFF_IRQ_ENABLE: rdata_raw = {29'h0000_0000, irq_enable_q};
         OFF_REQ_STATUS: rdata_raw = fail_count_q;
         default: rdata_raw = 32'h0000_0000;
      endcase
   end

   byte_order_swap u_swap_rd
   (
      .i_swap (ctrl_q[CTRL_LEGACY]),
      .i_data (rdata_raw),
      .o_data (rdata_ord)
   );

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_rdata <= 32'h0000_0000;
      else if (i_reg.rd)
         o_rdata <= rdata_ord;
      else
         o_rdata <= 32'h0000_0000;
   end

   sense_reset_a: assert property (@(posedge i_clk)
      i_sys_rst |=> sense_size_q == SENSE_SIZE_RST
      && cdb_size_q == CDB_SIZE_RST)
      else $error("size fields not restored by reset");

   sense_write_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_reg.wr && i_reg.addr == OFF_SENSE_SIZE && !ctrl_q[CTRL_LEGACY]
      |=> sense_size_q == $past(i_reg.wdata))
      else $error("sense size write lost");

   cdb_write_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_reg.wr && i_reg.addr == OFF_CDB_SIZE && !ctrl_q[CTRL_LEGACY]
      |=> cdb_size_q == $past(i_reg.wdata))
      else $error("cdb size write lost");

   bidir_fail_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_cmd.valid && ctrl_q[CTRL_READY] && i_cmd.has_in && i_cmd.has_out
      && !feat_q[FEAT_INOUT] |=> o_cmd_rsp.valid
      && o_cmd_rsp.resp == RESP_FAILURE)
      else $error("bidirectional request not failed");

   bidir_ok_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_cmd.valid && ctrl_q[CTRL_READY] && feat_q[FEAT_INOUT]
      |=> o_cmd_rsp.valid && o_cmd_rsp.resp == RESP_OK)
      else $error("request failed with in/out negotiated");

   hotplug_evt_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_hotplug_event |-> $past(feat_q[FEAT_HOTPLUG]))
      else $error("hot-plug event without feature");

   param_evt_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_unit_param_change && feat_q[FEAT_CHANGE]
      |=> o_param_event && irq_status_q[IRQ_PARAM])
      else $error("parameter change not reported");

   ready_accept_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_cmd.valid && !ctrl_q[CTRL_READY] |=> !o_cmd_rsp.valid)
      else $error("request answered before ready");

   scan_limit_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_reg.rd && i_reg.addr == OFF_UNIT_LIMIT && !ctrl_q[CTRL_LEGACY]
      |=> o_rdata == UNIT_LIMIT_VAL)
      else $error("unit limit read wrong");

   fill_size_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      feat_q[FEAT_CHANGE] |-> event_fill > EVENT_FILL_BASE)
      else $error("event fill size ignores features");

   hotplug_set_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_unit_hotplug && feat_q[FEAT_HOTPLUG]
      |=> o_hotplug_event && irq_status_q[IRQ_HOTPLUG])
      else $error("hot-plug not reported");

   param_off_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_unit_param_change && !feat_q[FEAT_CHANGE] |=> !o_param_event)
      else $error("parameter change reported without feature");

   status_hold_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      irq_status_q[IRQ_HOTPLUG]
      && !(i_reg.wr && i_reg.addr == OFF_IRQ_CLEAR)
      |=> irq_status_q[IRQ_HOTPLUG])
      else $error("status bit lost without clear");

   irq_on_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      |(irq_status_q & irq_enable_q) |=> o_irq)
      else $error("interrupt not raised for enabled status");

   irq_off_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      irq_enable_q == '0 |=> !o_irq)
      else $error("interrupt raised with all sources disabled");

   fail_status_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_cmd.valid && ctrl_q[CTRL_READY] && cmd_fail
      |=> irq_status_q[IRQ_REQ_FAIL])
      else $error("failed request not flagged");

   fail_count_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_cmd.valid && ctrl_q[CTRL_READY] && cmd_fail
      |=> fail_count_q == $past(fail_count_q) + 32'h0000_0001)
      else $error("failed request not counted");

   accept_on_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      ctrl_q[CTRL_READY] |=> o_cmd_accept)
      else $error("ready set but requests not accepted");

   feat_latch_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_features_valid
      |=> feat_q == ($past(i_drv_features) & FEAT_OFFERED))
      else $error("negotiated features not latched");

   sense_hold_a: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      !(i_reg.wr && i_reg.addr == OFF_SENSE_SIZE)
      |=> $stable(sense_size_q))
      else $error("sense size changed without a write");
endmodule

// ---- rtl/scsi_cfg_pkg.sv ----
package scsi_cfg_pkg;
   // register byte offsets on the plain port
   localparam logic [7:0] OFF_QUEUE_COUNT = 8'h00;
   localparam logic [7:0] OFF_SEG_MAX = 8'h04;
   localparam logic [7:0] OFF_XFER_HINT = 8'h08;
   localparam logic [7:0] OFF_LINKED_LIMIT = 8'h0c;
   localparam logic [7:0] OFF_EVENT_FILL = 8'h10;
   localparam logic [7:0] OFF_SENSE_SIZE = 8'h14;
   localparam logic [7:0] OFF_CDB_SIZE = 8'h18;
   localparam logic [7:0] OFF_CHAN_TGT = 8'h1c;
   localparam logic [7:0] OFF_UNIT_LIMIT = 8'h20;
   localparam logic [7:0] OFF_FEATURES = 8'h24;
   localparam logic [7:0] OFF_CTRL = 8'h28;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h2c;
   localparam logic [7:0] OFF_IRQ_CLEAR = 8'h30;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h34;
   localparam logic [7:0] OFF_REQ_STATUS = 8'h38;

   // defaults
   localparam logic [31:0] SENSE_SIZE_RST = 32'h0000_0060;
   localparam logic [31:0] CDB_SIZE_RST = 32'h0000_0020;
   localparam logic [31:0] QUEUE_COUNT_VAL = 32'h0000_0001;
   localparam logic [31:0] SEG_MAX_VAL = 32'h0000_0080;
   localparam logic [31:0] XFER_HINT_VAL = 32'h0000_ffff;
   localparam logic [31:0] LINKED_LIMIT_VAL = 32'h0000_0080;
   localparam logic [31:0] EVENT_FILL_BASE = 32'h0000_0010;
   localparam logic [31:0] EVENT_FILL_EXT = 32'h0000_0010;
   localparam logic [15:0] CHAN_LIMIT_VAL = 16'h0000;
   localparam logic [15:0] TGT_LIMIT_VAL = 16'h00ff;
   localparam logic [31:0] UNIT_LIMIT_VAL = 32'h0000_3fff;

   // feature bit positions
   localparam int FEAT_INOUT = 0;
   localparam int FEAT_HOTPLUG = 1;
   localparam int FEAT_CHANGE = 2;
   localparam int FEAT_PROT = 3;
   localparam logic [3:0] FEAT_OFFERED = 4'hf;

   // control bits
   localparam int CTRL_READY = 0;
   localparam int CTRL_LEGACY = 1;

   // interrupt bit positions
   localparam int IRQ_HOTPLUG = 0;
   localparam int IRQ_PARAM = 1;
   localparam int IRQ_REQ_FAIL = 2;
   localparam int IRQ_W = 3;

   localparam logic [7:0] RESP_OK = 8'h00;
   localparam logic [7:0] RESP_FAILURE = 8'h09;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic has_out;
      logic has_in;
      logic has_prot;
   } cmd_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] resp;
   } cmd_rsp_t;
endpackage

// ---- rtl/byte_order_swap.sv ----
`timescale 1ns/1ps
module byte_order_swap
   (
   input wire logic i_swap,
   input wire logic [31:0] i_data,
   output logic [31:0] o_data
   );
   // legacy guests may be big-endian natively
   assign o_data = i_swap ?
      {i_data[7:0], i_data[15:8], i_data[23:16], i_data[31:24]} : i_data;
endmodule

// ---- dv/guest_initiator_model.sv ----
`timescale 1ns/1ps
module guest_initiator_model
   import scsi_cfg_pkg::*;
   (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_go,
   input wire logic i_out,
   input wire logic i_in,
   input wire logic i_skip_wait,
   input wire logic i_accept,
   output cmd_req_t o_cmd
   );
   // one request per go pulse keeps linked commands within limit
   // skip_wait breaks the ready rule on purpose, to see a refusal
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_cmd <= '0;
      end
      else
      begin
         o_cmd.valid <= i_go & (i_accept | i_skip_wait);
         // flags invert outside requests so stale values never match
         o_cmd.has_out <= i_go ? i_out : ~o_cmd.has_out;
         o_cmd.has_in <= i_go ? i_in : ~o_cmd.has_in;
         o_cmd.has_prot <= 1'b0;
      end
   end
endmodule

// ---- dv/scsi_host_config_space_test.sv ----
`timescale 1ns/1ps
module scsi_host_config_space_test
   import scsi_cfg_pkg::*;
   ;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   reg_req_t i_reg = '0;
   logic [31:0] o_rdata, v, sense_o, cdb_o;
   logic [3:0] feat = 4'h0;
   logic [3:0] feat_o;
   logic feat_v = 1'b0, hp = 1'b0, pc = 1'b0, go = 1'b0;
   logic c_out = 1'b0, c_in = 1'b0, skip = 1'b0;
   logic accept, hp_ev, pc_ev, irq;
   cmd_req_t cmd;
   cmd_rsp_t rsp;
   int num_errors = 0;
   int n_compared = 0;
   logic [7:0] ra [11] = '{OFF_QUEUE_COUNT, OFF_SEG_MAX, OFF_XFER_HINT,
      OFF_LINKED_LIMIT, OFF_EVENT_FILL, OFF_SENSE_SIZE, OFF_CDB_SIZE,
      OFF_CHAN_TGT, OFF_UNIT_LIMIT, OFF_FEATURES, 8'h3c};
   logic [31:0] rv [11] = '{QUEUE_COUNT_VAL, SEG_MAX_VAL, XFER_HINT_VAL,
      LINKED_LIMIT_VAL, EVENT_FILL_BASE, 32'h0000_0060, 32'h0000_0020,
      32'h00ff_0000, 32'h0000_3fff, 32'h0000_0000, 32'h0000_0000};

   always #10 i_clk = ~i_clk;

   scsi_host_config_space dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_reg(i_reg), .o_rdata(o_rdata), .i_drv_features(feat),
      .i_features_valid(feat_v), .i_unit_hotplug(hp),
      .i_unit_param_change(pc), .i_cmd(cmd), .o_cmd_rsp(rsp),
      .o_cmd_accept(accept), .o_features(feat_o), .o_sense_size(sense_o),
      .o_cdb_size(cdb_o), .o_hotplug_event(hp_ev), .o_param_event(pc_ev),
      .o_irq(irq));

   guest_initiator_model model_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_go(go), .i_out(c_out), .i_in(c_in), .i_skip_wait(skip),
      .i_accept(accept), .o_cmd(cmd));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_reg <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      i_reg.wr <= 1'b0;
   endtask

   // read data stand one cycle only, so sample just after that edge
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_reg <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      i_reg.rd <= 1'b0;
      #1 v = o_rdata;
   endtask

   task automatic pulse(input logic [3:0] m);
      @(posedge i_clk);
      {go, feat_v, pc, hp} <= m;
      @(posedge i_clk);
      {go, feat_v, pc, hp} <= 4'h0;
      #1;
   endtask

   task automatic rst();
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (8) @(posedge i_clk);
      i_sys_rst <= 1'b0;
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge i_clk);
      num_errors++;
      print_verdict();
   end

   initial
   begin
      rst();
      for (int i = 0; i < 11; i++)
      begin
         rd(ra[i]);
         chk(v, rv[i]);
      end
      $display("test defaults done");
      wr(OFF_SEG_MAX, 32'h0000_0005);
      wr(OFF_SENSE_SIZE, 32'h0000_0040);
      wr(OFF_CDB_SIZE, 32'h0000_0010);
      rd(OFF_SEG_MAX);
      chk(v, SEG_MAX_VAL);
      rd(OFF_SENSE_SIZE);
      chk(v, 32'h0000_0040);
      chk(cdb_o, 32'h0000_0010);
      rst();
      rd(OFF_CDB_SIZE);
      chk(v, 32'h0000_0020);
      chk(sense_o, 32'h0000_0060);
      $display("test sizes done");
      wr(OFF_IRQ_ENABLE, 32'h0000_0007);
      pulse(4'h1);
      chk({hp_ev, irq}, 32'h0000_0000);
      feat <= 4'h6;
      pulse(4'h4);
      rd(OFF_EVENT_FILL);
      chk(v, 32'h0000_0020);
      chk(feat_o, 4'h6);
      pulse(4'h1);
      chk({hp_ev, irq}, 32'h0000_0003);
      pulse(4'h2);
      chk({pc_ev, irq}, 32'h0000_0003);
      wr(OFF_IRQ_ENABLE, 32'h0000_0000);
      wr(OFF_IRQ_CLEAR, 32'h0000_0003);
      pulse(4'h1);
      rd(OFF_IRQ_STATUS);
      chk(v, 32'h0000_0001);
      chk(irq, 32'h0000_0000);
      wr(OFF_IRQ_CLEAR, 32'h0000_0001);
      $display("test events done");
      // ready is still low: a forced request must get no answer
      skip <= 1'b1;
      c_in <= 1'b1;
      c_out <= 1'b1;
      pulse(4'h8);
      @(posedge i_clk);
      #1 chk(rsp.valid, 32'h0000_0000);
      skip <= 1'b0;
      wr(OFF_CTRL, 32'h0000_0001);
      rd(OFF_IRQ_ENABLE);
      chk(accept, 32'h0000_0001);
      pulse(4'h8);
      @(posedge i_clk);
      #1 chk(rsp, {1'b1, RESP_FAILURE});
      rd(OFF_IRQ_STATUS);
      chk(v, 32'h0000_0004);
      rd(OFF_REQ_STATUS);
      chk(v, 32'h0000_0001);
      feat <= 4'h9;
      pulse(4'h4);
      pulse(4'h8);
      @(posedge i_clk);
      #1 chk(rsp, {1'b1, RESP_OK});
      chk(feat_o, 4'h9);
      rd(OFF_EVENT_FILL);
      chk(v, 32'h0000_0010);
      pulse(4'h2);
      chk(pc_ev, 32'h0000_0000);
      $display("test requests done");
      wr(OFF_CTRL, 32'h0000_0003);
      rd(OFF_SENSE_SIZE);
      chk(v, 32'h6000_0000);
      rd(OFF_CTRL);
      chk(v, 32'h0300_0000);
      wr(OFF_CTRL, 32'h0000_0001);
      rd(OFF_SENSE_SIZE);
      chk(v, 32'h0000_0060);
      $display("test byte order done");
      print_verdict();
   end
endmodule
